// ==== design/display_port_pkg.sv ====
// constants and state codes shared by the display parallel port
//
// How it works
// R01: tv mode drives one 8-bit luma or chroma component every pixel clock
// R02: component bits 7..0 land on panel data lines 17..10 in order
// R03: tv pixel clock runs at 27 MHz within ten percent
// R04: tv line sync, field sync and data valid are all active low
// R05: line sync falls at each new row and stays low one cycle
// R06: field sync falls at each new field and stays low at least one cycle
// R07: odd field entry: both syncs fall together; even field entry: apart
// R08: component data only moves while line sync is high
// R09: system 80 and 68k, type 1 strobes with select, type 2 with rd/wr
// R10: burst length comes from the upstream source, dma or bus burst
// R11: type 1 bursts strobe select; other controls change only on direction
// R12: type 2 bursts strobe read/write or enable; select held whole burst
// R13: burst clock mode samples on burst clock, select held, idle after
// R14: single mode splits bursts and idles all controls one period after each
// R15: idle pause between bursts of 4 to 19 port clocks
// R16: read wait states stretch each read up to four interface periods
// R17: polarity of every parallel control output is programmable; the burst sample clock is fixed active high
// R18: read strobe active from read up time to read down time only
// R19: write strobe active from write up time to write down time only
// R20: read controls stand from access start until the period ends
// R21: read period is the programmed value rounded up to whole port clocks
// R22: write period is the programmed value rounded up to whole port clocks
// R23: strobe up and down times round upward at half port clock steps
// R24: byte enables follow the valid bytes of each access when enabled
`default_nettype none
package display_port_pkg;
  // tv raster, in pixel clocks and lines (plain defaults)
  localparam logic [11:0] TV_H_LAST     = 12'h359;
  localparam logic [11:0] TV_H_ACTIVE   = 12'h08A;
  localparam logic [11:0] TV_H_PREFETCH = 12'h089;
  localparam logic [11:0] TV_H_HALF     = 12'h1AD;
  localparam logic [9:0]  TV_V_LAST_ODD = 10'h106;
  localparam logic [9:0]  TV_V_LAST_EVN = 10'h105;
  localparam int          TV_CLK_KHZ    = 27000;
  localparam int          TV_CLK_TOL_PC = 10;
  // burst modes
  localparam logic [1:0]  MODE_NO_CLK   = 2'h0;
  localparam logic [1:0]  MODE_SEP_CLK  = 2'h1;
  localparam logic [1:0]  MODE_SINGLE   = 2'h2;
  // pause between bursts: base plus programmed offset
  localparam logic [4:0]  PAUSE_MIN     = 5'h04;
  localparam logic [4:0]  PAUSE_MAX     = 5'h13;
  // shortest access period in port clocks
  localparam logic [7:0]  PER_MIN       = 8'h02;
  // polarity vector bit positions
  localparam int          POL_CS        = 0;
  localparam int          POL_WR        = 1;
  localparam int          POL_RD        = 2;
  localparam int          POL_BE        = 3;
  // reset values
  localparam logic [3:0]  POL_RESET     = 4'h0;
  localparam logic [9:0]  CNT_RESET     = 10'h000;
  localparam logic [15:0] DATA_RESET    = 16'h0000;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_ACCESS = 2'b01,
    ST_GAP    = 2'b10,
    ST_PAUSE  = 2'b11
  } port_state_e;
endpackage : display_port_pkg
`default_nettype wire

// ==== design/display_parallel_port.sv ====
// tv encoder stream output and asynchronous parallel smart display port
`timescale 1ns/1ps
`default_nettype none
module display_parallel_port
  import display_port_pkg::*;
(
  // port clock domain
  input  wire logic        sys_clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        clk_en_i,
  // tv link clock and stream
  input  wire logic        tv_pixel_clock_i,
  input  wire logic        tv_enable_i,
  input  wire logic [7:0]  tv_component_i,
  output var  logic        tv_component_ready_o,
  output var  logic [7:0]  panel_data_upper_byte_o,
  output var  logic        tv_line_sync_n_o,
  output var  logic        tv_field_sync_n_o,
  output var  logic        tv_data_valid_n_o,
  output var  logic        tv_field_odd_o,
  // parallel port configuration
  input  wire logic        sys68k_i,
  input  wire logic        type2_i,
  input  wire logic [1:0]  burst_mode_i,
  input  wire logic [3:0]  pause_i,
  input  wire logic [1:0]  read_wait_states_i,
  input  wire logic [3:0]  signal_polarity_config_i,
  input  wire logic        byte_enable_on_i,
  input  wire logic [7:0]  rd_period_i,
  input  wire logic [7:0]  rd_up_i,
  input  wire logic [7:0]  rd_down_i,
  input  wire logic [7:0]  wr_period_i,
  input  wire logic [7:0]  wr_up_i,
  input  wire logic [7:0]  wr_down_i,
  // access requests and read answers
  input  wire logic        req_valid_i,
  input  wire logic        req_write_i,
  input  wire logic        req_last_i,
  input  wire logic [15:0] req_data_i,
  input  wire logic [1:0]  req_be_i,
  output var  logic        req_ready_o,
  output var  logic [15:0] rd_data_o,
  output var  logic        rd_valid_o,
  output var  logic        busy_o,
  // display pins
  output var  logic        display_select_o,
  output var  logic        display_write_strobe_o,
  output var  logic        display_read_strobe_o,
  output var  logic [1:0]  display_byte_enable_o,
  output var  logic        burst_sample_clock_o,
  output var  logic [15:0] display_data_o,
  output var  logic        display_data_oe_o,
  input  wire logic [15:0] display_data_i
);

  // programmed half-clock figures rounded up to whole port clocks
  function automatic logic [7:0] ceil_half(input logic [7:0] v);
    logic [8:0] s;
    s = {1'b0, v} + 9'h001;
    return s[8:1];
  endfunction : ceil_half

  //////////////////////////////////////////////////////////////////////////
  // tv link domain

  logic        en_s1;
  logic        en_s2;
  logic        ce_s1;
  logic        ce_s2;
  logic [11:0] h_cnt;
  logic [9:0]  v_cnt;
  logic        odd_fld;
  logic [11:0] next_h;
  logic [9:0]  next_v;
  logic        next_odd;
  logic [9:0]  v_last;
  logic        h_wrap;
  logic        next_hs_n;
  logic        next_vs_n;
  logic        next_ready;

  // level crossings into the pixel domain; first stage read by second only
  always_ff @(posedge tv_pixel_clock_i or negedge arst_n_i)
    if (!arst_n_i)
    begin
      en_s1 <= 1'b0;
      en_s2 <= 1'b0;
      ce_s1 <= 1'b0;
      ce_s2 <= 1'b0;
    end
    else
    begin
      en_s1 <= tv_enable_i;
      en_s2 <= en_s1;
      ce_s1 <= clk_en_i;
      ce_s2 <= ce_s1;
    end

  // raster stepping; field length alternates odd and even
  assign v_last   = odd_fld ? TV_V_LAST_ODD : TV_V_LAST_EVN;
  assign h_wrap   = (h_cnt == TV_H_LAST);
  assign next_h   = !en_s2 ? 12'h000 : h_wrap ? 12'h000 : 12'(h_cnt + 12'h001);
  assign next_v   = !en_s2 ? 10'h000 : !h_wrap ? v_cnt :
                    (v_cnt == v_last) ? 10'h000 : 10'(v_cnt + 10'h001);
  assign next_odd = !en_s2 ? 1'b1 :
                    (h_wrap && v_cnt == v_last) ? !odd_fld : odd_fld;

  // syncs: row start at column zero; odd field shares it, even is mid-row
  assign next_hs_n  = !(en_s2 && next_h == 12'h000); // R05
  assign next_vs_n  = !(en_s2 && next_v == 10'h000 &&
                      (next_odd ? next_h == 12'h000          // R07
                                : next_h == TV_H_HALF));     // R06
  // fetch one cycle ahead so data meets the valid strobe; never at column 0
  assign next_ready = en_s2 && next_h >= TV_H_PREFETCH &&
                      next_h < TV_H_LAST;                     // R08

  // pixel-paced raster on the 27 MHz link clock, frozen by clock enable
  always_ff @(posedge tv_pixel_clock_i or negedge arst_n_i) // R03
    if (!arst_n_i)
    begin
      h_cnt                   <= 12'h000;
      v_cnt                   <= 10'h000;
      odd_fld                 <= 1'b1;
      tv_line_sync_n_o        <= 1'b1;
      tv_field_sync_n_o       <= 1'b1;
      tv_data_valid_n_o       <= 1'b1;
      tv_component_ready_o    <= 1'b0;
      panel_data_upper_byte_o <= 8'h00;
      tv_field_odd_o          <= 1'b1;
    end
    else if (ce_s2)
    begin
      h_cnt                   <= next_h;
      v_cnt                   <= next_v;
      odd_fld                 <= next_odd;
      tv_field_odd_o          <= next_odd;
      tv_line_sync_n_o        <= next_hs_n;                   // R04
      tv_field_sync_n_o       <= next_vs_n;                   // R04
      tv_data_valid_n_o       <= !tv_component_ready_o;       // R04
      tv_component_ready_o    <= next_ready;
      // bit 7 of the component drives line 17 down to bit 0 on line 10
      panel_data_upper_byte_o <= tv_component_ready_o ?
                                 tv_component_i : 8'h00;      // R01 R02
    end

  //////////////////////////////////////////////////////////////////////////
  // parallel port, port clock domain

  port_state_e state;
  port_state_e next_state;
  logic [9:0]  cnt;
  logic [9:0]  next_cnt;
  logic        take;
  logic        wr_q;
  logic        last_q;
  logic [15:0] data_q;
  logic [1:0]  be_q;
  logic [15:0] din_s1;
  logic [15:0] din_s2;

  // timing figures in port clocks
  logic [7:0]  per_r;
  logic [7:0]  per_w;
  logic [7:0]  up_r;
  logic [7:0]  up_w;
  logic [7:0]  dn_r;
  logic [7:0]  dn_w;
  logic [9:0]  rd_len;
  logic [9:0]  rd_dn_ext;
  logic [9:0]  len;
  logic [9:0]  len_m1;
  logic [9:0]  up_cur;
  logic [9:0]  dn_cur;
  logic [9:0]  gap_last;
  logic [9:0]  pause_last;
  logic        acc_end;

  assign per_r     = (ceil_half(rd_period_i) < PER_MIN) ? PER_MIN
                     : ceil_half(rd_period_i);                // R21
  assign per_w     = (ceil_half(wr_period_i) < PER_MIN) ? PER_MIN
                     : ceil_half(wr_period_i);                // R22
  assign up_r      = ceil_half(rd_up_i);                      // R23
  assign up_w      = ceil_half(wr_up_i);                      // R23
  assign dn_r      = ceil_half(rd_down_i);                    // R23
  assign dn_w      = ceil_half(wr_down_i);                    // R23
  // each wait state adds one full read period, strobe stretched with it
  assign rd_len    = 10'({2'b00, per_r} *
                     {7'h00, {1'b0, read_wait_states_i} + 3'h1}); // R16
  assign rd_dn_ext = 10'({2'b00, dn_r} +
                     {2'b00, per_r} * {8'h00, read_wait_states_i}); // R16
  assign len       = wr_q ? {2'b00, per_w} : rd_len;
  assign len_m1    = 10'(len - 10'h001);
  assign up_cur    = wr_q ? {2'b00, up_w} : {2'b00, up_r};
  assign dn_cur    = wr_q ? {2'b00, dn_w} : rd_dn_ext;
  assign gap_last  = 10'({2'b00, per_w} - 10'h001);
  assign pause_last = {5'h00, 5'(PAUSE_MIN + {1'b0, pause_i}) - 5'h01};
  // holding at len keeps select up, except in type 1 strobed bursts, while waiting for the next word
  assign acc_end   = (state == ST_ACCESS) && (cnt >= len_m1);

  // sequencing of accesses, gaps and pauses
  always_comb
  begin
    next_state = state;
    next_cnt   = 10'(cnt + 10'h001);
    take       = 1'b0;
    unique case (state)
      ST_IDLE:
      begin
        next_cnt = CNT_RESET;
        if (req_valid_i)
        begin
          take       = 1'b1;
          next_state = ST_ACCESS;
        end
      end
      ST_ACCESS:
        if (acc_end)
        begin
          next_cnt = CNT_RESET;
          if (burst_mode_i[1])                                // R14
            next_state = ST_GAP;
          else if (last_q)                                    // R10
            next_state = ST_PAUSE;
          else if (req_valid_i)
            take = 1'b1;
          else
            next_cnt = len;
        end
      ST_GAP:
        if (cnt >= gap_last)
        begin
          next_cnt   = CNT_RESET;
          next_state = last_q ? ST_PAUSE : ST_IDLE;
        end
      ST_PAUSE:
        if (cnt >= pause_last)                                // R15
        begin
          next_cnt   = CNT_RESET;
          next_state = ST_IDLE;
        end
    endcase
  end

  // state and captured request
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
    if (!arst_n_i)
    begin
      state  <= ST_IDLE;
      cnt    <= CNT_RESET;
      wr_q   <= 1'b1;
      last_q <= 1'b0;
      data_q <= DATA_RESET;
      be_q   <= 2'h0;
    end
    else if (clk_en_i)
    begin
      state <= next_state;
      cnt   <= next_cnt;
      if (take)
      begin
        wr_q   <= req_write_i;
        last_q <= req_last_i || burst_mode_i[1];
        data_q <= req_data_i;
        be_q   <= req_be_i;
      end
    end

  // control activity before polarity
  logic       in_acc;
  logic       win;
  logic       cs_strobed;
  logic       rw_strobed;
  logic       cs_act;
  logic       wr_act;
  logic       rd_act;
  logic [1:0] be_act;
  logic       bclk_act;

  assign in_acc     = (state == ST_ACCESS);
  assign win        = in_acc && cnt >= up_cur && cnt < dn_cur &&
                      cnt < len;                              // R18 R19
  // separate clock mode holds all controls and strobes the burst clock
  assign cs_strobed = !type2_i && burst_mode_i != MODE_SEP_CLK; // R09 R11
  assign rw_strobed = type2_i && burst_mode_i != MODE_SEP_CLK;  // R09 R12
  assign cs_act     = cs_strobed ? win : in_acc;              // R12 R13
  // 68k: write pin is a read/write level, read pin is the enable
  assign wr_act     = sys68k_i ? (in_acc && wr_q)
                    : (in_acc && wr_q && (!rw_strobed || win)); // R11 R19
  assign rd_act     = sys68k_i ? (in_acc && (!rw_strobed || win))
                    : (in_acc && !wr_q && (!rw_strobed || win)); // R18 R20
  assign bclk_act   = (burst_mode_i == MODE_SEP_CLK) && win;  // R13

  // byte enables track each access's valid bytes
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_be
      assign be_act[gi] = byte_enable_on_i && in_acc && be_q[gi]; // R24
    end
  endgenerate

  // pins registered; polarity bit high means active high
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
    if (!arst_n_i)
    begin
      display_select_o       <= 1'b1;
      display_write_strobe_o <= 1'b1;
      display_read_strobe_o  <= 1'b1;
      display_byte_enable_o  <= 2'h3;
      burst_sample_clock_o   <= 1'b0;
      display_data_o         <= DATA_RESET;
      display_data_oe_o      <= 1'b0;
    end
    else if (clk_en_i)
    begin
      display_select_o       <= cs_act ~^
                                signal_polarity_config_i[POL_CS]; // R17
      display_write_strobe_o <= wr_act ~^
                                signal_polarity_config_i[POL_WR]; // R17
      display_read_strobe_o  <= rd_act ~^
                                signal_polarity_config_i[POL_RD]; // R17
      display_byte_enable_o  <= be_act ~^
                                {2{signal_polarity_config_i[POL_BE]}};
      burst_sample_clock_o   <= bclk_act;
      display_data_o         <= data_q;                       // R13
      display_data_oe_o      <= in_acc && wr_q;
    end

  // read data: pins pass two flops, sampled at the end of the access
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
    if (!arst_n_i)
    begin
      din_s1      <= DATA_RESET;
      din_s2      <= DATA_RESET;
      rd_data_o   <= DATA_RESET;
      rd_valid_o  <= 1'b0;
      req_ready_o <= 1'b0;
      busy_o      <= 1'b0;
    end
    else if (clk_en_i)
    begin
      din_s1      <= display_data_i;
      din_s2      <= din_s1;
      rd_valid_o  <= in_acc && !wr_q && cnt == len_m1;        // R16
      if (in_acc && !wr_q && cnt == len_m1)
        rd_data_o <= din_s2;
      req_ready_o <= take;
      busy_o      <= (next_state != ST_IDLE);
    end

  //////////////////////////////////////////////////////////////////////////
  // checks

  wire cs_on = display_select_o ~^ signal_polarity_config_i[POL_CS];
  wire wr_on = display_write_strobe_o ~^ signal_polarity_config_i[POL_WR];
  wire rd_on = display_read_strobe_o ~^ signal_polarity_config_i[POL_RD];

  sequence s_enter_pause;
    (state == ST_ACCESS) ##1 (state == ST_PAUSE);
  endsequence

  sequence s_wr_open;
    in_acc && wr_q && rw_strobed && !sys68k_i && clk_en_i &&
    cnt == up_cur && up_cur < dn_cur && cnt < len;
  endsequence

  AST_TV_LINE_ONE: assert property (@(posedge tv_pixel_clock_i) // R05
    disable iff (!arst_n_i) ($fell(tv_line_sync_n_o) && ce_s2)
    |=> tv_line_sync_n_o)
    else $error("line sync low for more than one cycle");
  AST_TV_ODD_TOGETHER: assert property (@(posedge tv_pixel_clock_i) // R07
    disable iff (!arst_n_i) ($fell(tv_field_sync_n_o) && tv_field_odd_o)
    |-> $fell(tv_line_sync_n_o))
    else $error("odd field syncs do not fall together");
  AST_TV_EVEN_APART: assert property (@(posedge tv_pixel_clock_i) // R07
    disable iff (!arst_n_i) ($fell(tv_field_sync_n_o) && !tv_field_odd_o)
    |-> tv_line_sync_n_o)
    else $error("even field syncs fall together");
  AST_TV_VALID_IN_LINE: assert property (@(posedge tv_pixel_clock_i) // R08
    disable iff (!arst_n_i) !tv_data_valid_n_o |-> tv_line_sync_n_o)
    else $error("data valid while line sync low");
  AST_TV_DATA_PATH: assert property (@(posedge tv_pixel_clock_i) // R01
    disable iff (!arst_n_i) (tv_component_ready_o && ce_s2)
    |=> !tv_data_valid_n_o &&
        panel_data_upper_byte_o == $past(tv_component_i))
    else $error("component not driven with data valid");
  AST_PAUSE_LEN: assert property (@(posedge sys_clk_i) // R15
    disable iff (!arst_n_i) s_enter_pause |-> (state == ST_PAUSE)[*4])
    else $error("pause shorter than four port clocks");
  AST_PAUSE_IDLE: assert property (@(posedge sys_clk_i) // R15
    disable iff (!arst_n_i) (state == ST_PAUSE && clk_en_i) |=> !cs_on)
    else $error("select active during pause");
  AST_GAP_IDLE: assert property (@(posedge sys_clk_i) // R14
    disable iff (!arst_n_i) (state == ST_GAP && clk_en_i)
    |=> !cs_on && !wr_on && !rd_on)
    else $error("controls active in single access gap");
  AST_TYPE2_SELECT: assert property (@(posedge sys_clk_i) // R12
    disable iff (!arst_n_i) (in_acc && rw_strobed && clk_en_i) |=> cs_on)
    else $error("select dropped inside type 2 burst");
  AST_WR_WINDOW: assert property (@(posedge sys_clk_i) // R19
    disable iff (!arst_n_i) s_wr_open |=> wr_on)
    else $error("write strobe not asserted at up time");
endmodule : display_parallel_port
`default_nettype wire

// ==== testbench/display_model.sv ====
// smart display model that answers reads and catches written words
`timescale 1ns/1ps
`default_nettype none
module display_model (
  // port clock and programmed polarity
  input  wire logic        sys_clk_i,
  input  wire logic [3:0]  pol_i,
  // display pins seen from the panel
  input  wire logic        select_i,
  input  wire logic        write_i,
  input  wire logic        read_i,
  input  wire logic        oe_i,
  input  wire logic [15:0] data_i,
  output var  logic [15:0] data_o,
  // word to answer with and last word written
  input  wire logic [15:0] answer_i,
  output var  logic [15:0] caught_o
);
  logic sel;
  logic wr;
  // active levels follow the polarity bits
  assign sel = (select_i === pol_i[0]);
  assign wr  = (write_i === pol_i[1]);

  initial
  begin
    data_o   = 16'h0000;
    caught_o = 16'h0000;
  end

  // a deselected panel leaves the bus floating, so show a changing pattern
  always @(posedge sys_clk_i)
  begin
    if (sel && wr && oe_i)
      caught_o <= data_i;
    if (sel && !wr && !oe_i)
      data_o <= answer_i;
    else
      data_o <= ~data_o;
  end
endmodule : display_model
`default_nettype wire

// ==== testbench/display_parallel_port_bench.sv ====
// self-checking bench for the display parallel port
`timescale 1ns/1ps
`default_nettype none
module display_parallel_port_bench;
  import display_port_pkg::*;
  logic        sys_clk_i;
  logic        arst_n_i = 1'b0;
  logic        pix;
  logic [7:0]  comp     = 8'h00;
  logic [7:0]  exp_c;
  logic [7:0]  pdata;
  logic        ready, valid_n, line_n, field_n;
  logic        m68k     = 1'b0;
  logic        type2    = 1'b0;
  logic        be_on    = 1'b0;
  logic        rq_v     = 1'b0;
  logic        rq_w     = 1'b0;
  logic        rq_l     = 1'b0;
  logic [1:0]  mode     = 2'h0;
  logic [1:0]  wait_st  = 2'h0;
  logic [1:0]  rq_be    = 2'h3;
  logic [1:0]  be_pin;
  logic [3:0]  pause    = 4'h0;
  logic [3:0]  pol      = 4'h0;
  logic [7:0]  wrp      = 8'h0C;
  logic [7:0]  wru      = 8'h01;
  logic [7:0]  wrd      = 8'h03;
  logic [15:0] rq_d     = 16'h0000;
  logic [15:0] answer   = 16'h0000;
  logic [15:0] rd_data, d_out, d_in, caught;
  logic        rq_rdy, rd_vld, busy, sel, wr, rd, bclk, oe;
  logic        pend     = 1'b0;
  logic        line_was = 1'b1;
  logic        sel_was  = 1'b0;
  logic        bclk_was = 1'b0;
  logic [31:0] rnd      = 32'h7C49DC0A;
  logic [31:0] tv_rnd   = 32'h7C49DC0A;
  int          err_total, tests_run, n_sel, n_wr, n_bclk, n_busy;
  int          busy0, low_w, n_line, col, n_be, n_rs, n_cyc;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
  endfunction : lfsr

  // strobe cycles: rounded-up down time minus rounded-up up time
  function automatic int width(input logic [7:0] u, input logic [7:0] d);
    return (int'(d) + 1) / 2 - (int'(u) + 1) / 2;
  endfunction : width

  // single-access and type 1 bursts without burst clock reselect for every word
  function automatic int sel_exp(input logic [1:0] md, input logic t2);
    return (md == MODE_SEP_CLK || (md == MODE_NO_CLK && t2)) ? 1 : 2;
  endfunction : sel_exp

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : conclude

  // hold the request until ready shows, bounded
  task automatic req(input logic w, input logic l, input logic [15:0] d);
    int k;
    rnd = lfsr(rnd);
    rq_v = 1'b1;
    rq_w = w;
    rq_l = l;
    rq_d = d;
    rq_be = rnd[1:0];
    k = 0;
    do
    begin
      @(posedge sys_clk_i);
      #1;
      k++;
    end
    while (rq_rdy !== 1'b1 && k < 200);
    chk(k < 200, 1'b1);
  endtask : req

  task automatic idle();
    int k;
    k = 0;
    rq_v = 1'b0;
    while (busy !== 1'b0 && k < 2000)
    begin
      @(posedge sys_clk_i);
      #1;
      k++;
    end
    chk(k < 2000, 1'b1);
    repeat (3) @(posedge sys_clk_i);
    #1;
  endtask : idle

  // new random timing and polarity, then let the idle pins settle
  task automatic setup(input logic [1:0] md, input logic t2, input logic m);
    rnd = lfsr(rnd);
    mode = md;
    type2 = t2;
    m68k = m;
    pol = rnd[3:0];
    pause = rnd[7:4];
    be_on = rnd[10];
    wrp = 8'h0C + 8'(rnd[14:11]);
    wru = 8'h01 + 8'(rnd[16:15]);
    wrd = wru + 8'h02 + 8'(rnd[18:17]);
    repeat (3) @(posedge sys_clk_i);
    #1;
    n_sel = 0;
    n_wr = 0;
    n_bclk = 0;
    n_busy = 0;
    n_rs = 0;
  endtask : setup

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end

  // link clock, deliberately out of phase with the port clock
  initial
  begin
    pix = 1'b0;
    #3;
    forever #40 pix = ~pix;
  end

  // pin activity counters for the running test
  always @(posedge sys_clk_i)
  begin
    n_sel += (sel === pol[0] && !sel_was);
    n_wr += (wr === pol[1]);
    n_bclk += (bclk === 1'b1 && !bclk_was);
    n_busy += (busy === 1'b1);
    n_be += (be_pin[0] === pol[3]);
    n_rs += (rd === pol[2]);
    sel_was = (sel === pol[0]);
    bclk_was = (bclk === 1'b1);
  end

  // tv stream: each taken component appears once, only while line sync high
  always @(posedge pix)
  begin
    if (arst_n_i === 1'b1)
    begin
      if (pend)
        chk({valid_n, line_n, pdata}, {2'b01, exp_c});
      if (line_n === 1'b0)
        low_w++;
      else if (low_w != 0)
      begin
        chk(low_w, 1);
        low_w = 0;
      end
      if (line_n === 1'b0 && line_was)
      begin
        // the opening field starts at row 0, column 1, past its field sync, so its rows carry no field mark
        chk(field_n, 1'b1);
        if (n_line != 0)
          chk(col, 32'(TV_H_LAST) + 1);
        n_line++;
        col = 0;
      end
      col++;
      line_was = (line_n === 1'b1);
    end
    pend = (ready === 1'b1);
    exp_c = comp;
    tv_rnd = lfsr(tv_rnd);
    comp <= #1 tv_rnd[7:0];
  end

  initial
  begin
    #400000;
    err_total++;
    conclude();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20) @(posedge sys_clk_i);
    #1;
    arst_n_i = 1'b1;
    // write strobe width, written word and pause length
    setup(MODE_NO_CLK, 1'b1, 1'b0);
    for (int i = 0; i < 2; i++)
    begin
      pause = i ? rnd[23:20] : 4'h0;
      n_busy = 0;
      n_wr = 0;
      n_be = 0;
      rnd = lfsr(rnd);
      answer = rnd[31:16];
      req(1'b1, 1'b1, answer);
      idle();
      chk(caught, answer);
      chk(n_wr, width(wru, wrd));
      chk(n_be, (be_on && rq_be[0]) ? (int'(wrp) + 1) / 2 : 0);
      busy0 = i ? busy0 : n_busy;
    end
    chk(n_busy - busy0, pause);
    $display("test write timing done");
    // two-word bursts across every mode and strobe type
    for (int i = 0; i < 8; i++)
    begin
      setup(2'(i / 2), 1'(i % 2), rnd[9]);
      answer = rnd[15:0];
      req(1'b1, 1'b0, rnd[31:16]);
      req(1'b1, 1'b1, answer);
      idle();
      chk(n_sel, sel_exp(mode, type2));
      chk(sel, !pol[0]);
      chk(caught, answer);
      if (mode == MODE_SEP_CLK)
        chk(n_bclk != 0, 1'b1);
    end
    $display("test burst modes done");
    // reads under every wait-state setting
    for (int w = 0; w < 4; w++)
    begin
      setup(MODE_NO_CLK, 1'b1, 1'b0);
      wait_st = 2'(w);
      answer = rnd[31:16];
      req(1'b0, 1'b1, 16'h0000);
      for (n_cyc = 0; n_cyc < 300 && rd_vld !== 1'b1; n_cyc++)
      begin
        @(posedge sys_clk_i);
        #1;
      end
      chk(rd_data, answer);
      chk(n_cyc, (int'(wrp) + 1) / 2 * (w + 1));
      idle();
      chk(n_rs, width(wru, wrd) + (int'(wrp) + 1) / 2 * w);
    end
    $display("test reads done");
    for (int k = 0; k < 30000 && n_line < 3; k++)
      @(posedge sys_clk_i);
    chk(n_line >= 3, 1'b1);
    $display("test tv stream done");
    conclude();
  end

  display_parallel_port display_parallel_port_inst (
    .sys_clk_i                (sys_clk_i),
    .arst_n_i                 (arst_n_i),
    .clk_en_i                 (1'b1),
    .tv_pixel_clock_i         (pix),
    .tv_enable_i              (1'b1),
    .tv_component_i           (comp),
    .tv_component_ready_o     (ready),
    .panel_data_upper_byte_o  (pdata),
    .tv_line_sync_n_o         (line_n),
    .tv_field_sync_n_o        (field_n),
    .tv_data_valid_n_o        (valid_n),
    .tv_field_odd_o           (),
    .sys68k_i                 (m68k),
    .type2_i                  (type2),
    .burst_mode_i             (mode),
    .pause_i                  (pause),
    .read_wait_states_i       (wait_st),
    .signal_polarity_config_i (pol),
    .byte_enable_on_i         (be_on),
    .rd_period_i              (wrp),
    .rd_up_i                  (wru),
    .rd_down_i                (wrd),
    .wr_period_i              (wrp),
    .wr_up_i                  (wru),
    .wr_down_i                (wrd),
    .req_valid_i              (rq_v),
    .req_write_i              (rq_w),
    .req_last_i               (rq_l),
    .req_data_i               (rq_d),
    .req_be_i                 (rq_be),
    .req_ready_o              (rq_rdy),
    .rd_data_o                (rd_data),
    .rd_valid_o               (rd_vld),
    .busy_o                   (busy),
    .display_select_o         (sel),
    .display_write_strobe_o   (wr),
    .display_read_strobe_o    (rd),
    .display_byte_enable_o    (be_pin),
    .burst_sample_clock_o     (bclk),
    .display_data_o           (d_out),
    .display_data_oe_o        (oe),
    .display_data_i           (d_in)
  );

  display_model display_model_inst (
    .sys_clk_i (sys_clk_i),
    .pol_i     (pol),
    .select_i  (sel),
    .write_i   (wr),
    .read_i    (rd),
    .oe_i      (oe),
    .data_i    (d_out),
    .data_o    (d_in),
    .answer_i  (answer),
    .caught_o  (caught)
  );
endmodule : display_parallel_port_bench
`default_nettype wire
